// ===== hw/dcw_map.svh
/*
 * Register offsets, field positions, reset values and timing counts for
 * the synthesizer control word decoder.
 * Assumes it is included by bare name after the package of types.
 */
`ifndef DCW_MAP_SVH
`define DCW_MAP_SVH

// Parallel port byte addresses (lowest byte of each word)
`define DCW_CTRL_OFS        6'h00
`define DCW_STEP_OFS        6'h04
`define DCW_RAMP_OFS        6'h08

// Control word field positions
`define DCW_FD_PUMP_HI      31
`define DCW_FD_PUMP_LO      30
`define DCW_FINAL_PUMP_HI   29
`define DCW_FINAL_PUMP_LO   27
`define DCW_WIDE_PUMP_HI    26
`define DCW_WIDE_PUMP_LO    24
`define DCW_AUTOCLR_FREQ    23
`define DCW_AUTOCLR_PHASE   22
`define DCW_RAMP_LOAD_FUD   21
`define DCW_CLR_FREQ        20
`define DCW_CLR_PHASE       19
`define DCW_FAST_LOCK_EN    17
`define DCW_FAST_LOCK_NOFTW 16
`define DCW_SWEEP_EN        15
`define DCW_SINE_SEL        14
`define DCW_PUMP_OFFSET     13
`define DCW_REF_DIV_HI      12
`define DCW_REF_DIV_LO      11
`define DCW_PUMP_POL        10
`define DCW_FB_DIV_HI       9
`define DCW_FB_DIV_LO       8
`define DCW_REF_HALVE_OFF   6
`define DCW_SYNC_OFF        5
`define DCW_PD_MIXER        4
`define DCW_PD_DETECTOR     3
`define DCW_PD_CORE         2
`define DCW_SDIO_IN_ONLY    1
`define DCW_LSB_FIRST       0

// Reset values
`define DCW_CTRL_RESET      32'h0020_0018
`define DCW_STEP_RESET      32'h0000_0000
`define DCW_RAMP_RESET      16'h0000

// Sync clock half period in core cycles
`define DCW_SYNC_HALF       3'h4

`endif

// ===== hw/dcw_pkg.sv
/*
 * Types for the synthesizer control word decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dcw_pkg;

   // Three-stage synchroniser for the strobe, address and data pin groups
   typedef struct packed {
      logic [2:0]  wr;
      logic [2:0]  rd;
      logic [2:0]  frequency_update_strobe;
      logic [17:0] addr;
      logic [23:0] data;
   } dcw_sync_s;

   // Whole state of the decoder
   typedef struct packed {
      dcw_sync_s   sync;
      logic        wr_f;
      logic        rd_f;
      logic        fud_f;
      logic [31:0] buf_ctrl;
      logic [31:0] buf_step;
      logic [15:0] buf_ramp;
      logic [31:0] ctrl;
      logic [31:0] step;
      logic [15:0] ramp;
      logic [15:0] ramp_timer;
      logic [31:0] freq_acc;
      logic [31:0] phase_acc;
      logic [2:0]  sync_cnt;
      logic        sync_clk;
      logic [7:0]  rd_data;
   } dcw_state_s;

endpackage : dcw_pkg

// ===== hw/dcw_decode.sv
/*
 * Control word and sweep step decoder of a direct digital synthesizer:
 * parallel byte port, update-strobe commit, frequency and phase
 * accumulators, ramp timer, sync clock and decoded control outputs.
 * Assumes port pins are asynchronous to CLOCK_IN and held stable around
 * their strobes; the tuning word comes from profile logic on CLOCK_IN.
 */
// Summary of operation
// - Final pump code 0xx zero, 1xx one-four
// - Wide pump scale is twice the code
// - Bit 23: clear frequency accumulator on update
// - Bit 22: clear phase accumulator on update
// - Bit 21: ramp timer reloads on update
// - Bit 20 holds frequency accumulator at zero
// - Bit 19 holds phase accumulator at zero
// - Bit 17 fast lock; 18, 7 unused
// - Bit 16: fast lock ignores tuning word
// - Bit 15 sweep adds accumulator to tuning
// - Bit 14 selects sine, else cosine
// - Bit 13 selects offset pump currents
// - Reference divider 1, 2, or 4
// - Feedback divider 1, 2, or 4
// - Bit 10 reverses pump source and sink
// - Bit 6 bypasses reference clock halving
// - Bit 5 holds sync pin low, timing runs
// - Bits 4:2 power down; all three sleep
// - Bit 1 makes serial data input-only
// - Bit 0 LSB first, serial mode only
// - Signed step word, MSB at 0x07
// - Detect pump code gives 0/20/40/60
// - Ramp divider spaces accumulation ticks
`timescale 1ns/1ps

`include "dcw_map.svh"

module dcw_decode
   import dcw_pkg::*;
(
   // Clock and reset
   input  wire logic        CLOCK_IN,
   input  wire logic        RESET_N_IN,
   // Parallel port pins
   input  wire logic        WRITE_N_IN,
   input  wire logic        READ_N_IN,
   input  wire logic [5:0]  ADDR_IN,
   input  wire logic [7:0]  DATA_IN,
   output logic      [7:0]  DATA_OUT,
   output logic             DATA_OE_N_OUT,
   input  wire logic        FREQ_UPDATE_IN,
   input  wire logic        SERIAL_MODE_IN,
   // Tuning word from profile logic
   input  wire logic [31:0] TUNING_WORD_IN,
   // Accumulators
   output logic      [31:0] FREQ_ACC_OUT,
   output logic      [31:0] PHASE_ACC_OUT,
   output logic             SWEEP_TICK_OUT,
   // Charge pump
   output logic      [6:0]  FD_PUMP_SCALE_OUT,
   output logic      [2:0]  FINAL_PUMP_SCALE_OUT,
   output logic      [3:0]  WIDE_PUMP_SCALE_OUT,
   output logic             PUMP_OFFSET_OUT,
   output logic             PUMP_POL_INVERT_OUT,
   output logic             FAST_LOCK_EN_OUT,
   output logic             FAST_LOCK_USE_TUNING_OUT,
   // Dividers and clocks
   output logic      [2:0]  REF_DIV_OUT,
   output logic      [2:0]  FB_DIV_OUT,
   output logic             REF_HALVE_EN_OUT,
   output logic             SYNC_CLOCK_OUT,
   // Modes and power
   output logic             SWEEP_MODE_OUT,
   output logic             SINE_SELECT_OUT,
   output logic             MIXER_PD_OUT,
   output logic             DETECTOR_PD_OUT,
   output logic             CORE_STOP_OUT,
   output logic             FULL_SLEEP_OUT,
   output logic             SERIAL_BIDIR_OUT,
   output logic             LSB_FIRST_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Divider code to ratio; low bit ignored when high bit set
   // Shared by the reference and feedback dividers
   function automatic logic [2:0] div_ratio(input logic [1:0] code);
      begin
         if (code[1])
            div_ratio = 3'h4;
         else if (code[0])
            div_ratio = 3'h2;
         else
            div_ratio = 3'h1;
      end
   endfunction : div_ratio

   // Byte lane of a word, 0 when address outside it
   // Address below the base wraps large and fails the compare
   function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [5:0] addr,
                                         input logic [5:0] base, input logic [2:0] nbytes);
      logic [5:0] rel;
      begin
         rel     = addr - base;
         byte_of = 8'h00;
         if (addr >= base && rel < {3'h0, nbytes})
            byte_of = word[rel[1:0]*8 +: 8];
      end
   endfunction : byte_of

   ////////////////////////////////////////////////////////////////////////////
   // State

   // Whole block state in one register; next value built below
   dcw_state_s st_r;
   dcw_state_s st_nxt;

   logic       wr_done;
   logic       fud_pulse;
   logic [5:0] waddr;
   logic [7:0] wdata;
   logic [5:0] raddr;
   logic [31:0] new_ctrl;
   logic       tick;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   // Pins pass three flops; filtered level moves once stages 2 and 3 agree
   // Address and data pipes are bus wide; the strobe hold time makes that safe
   always_comb
   begin
      st_nxt = st_r;
      new_ctrl = st_r.ctrl;
      tick = 1'b0;

      st_nxt.sync.wr   = {st_r.sync.wr[1:0], WRITE_N_IN};
      st_nxt.sync.rd   = {st_r.sync.rd[1:0], READ_N_IN};
      st_nxt.sync.frequency_update_strobe  = {st_r.sync.frequency_update_strobe[1:0], FREQ_UPDATE_IN};
      st_nxt.sync.addr = {st_r.sync.addr[11:0], ADDR_IN};
      st_nxt.sync.data = {st_r.sync.data[15:0], DATA_IN};
      if (st_r.sync.wr[1] == st_r.sync.wr[2])
         st_nxt.wr_f = st_r.sync.wr[2];
      if (st_r.sync.rd[1] == st_r.sync.rd[2])
         st_nxt.rd_f = st_r.sync.rd[2];
      if (st_r.sync.frequency_update_strobe[1] == st_r.sync.frequency_update_strobe[2])
         st_nxt.fud_f = st_r.sync.frequency_update_strobe[2];

      // Byte writes land in the port buffers, committed on update strobe
      if (wr_done)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (waddr == `DCW_CTRL_OFS + 6'(b))
               st_nxt.buf_ctrl[b*8 +: 8] = wdata;
            if (waddr == `DCW_STEP_OFS + 6'(b))
               st_nxt.buf_step[b*8 +: 8] = wdata;
            if (b < 2 && waddr == `DCW_RAMP_OFS + 6'(b))
               st_nxt.buf_ramp[b*8 +: 8] = wdata;
         end
      end

      // Strobe commits all three words in one cycle, so a half-written
      // word never reaches the accumulators
      if (fud_pulse)
      begin
         new_ctrl       = st_r.buf_ctrl;
         st_nxt.ctrl    = st_r.buf_ctrl;
         st_nxt.step    = st_r.buf_step;
         st_nxt.ramp    = st_r.buf_ramp;
      end

      // Ramp timer keeps counting even while the core is stopped
      // Limitation: with bit 21 set it also reloads on timeout, not only on update
      if (st_r.ramp_timer == 16'h0000)
      begin
         tick = new_ctrl[`DCW_SWEEP_EN];
         st_nxt.ramp_timer = st_nxt.ramp;
      end
      else
         st_nxt.ramp_timer = st_r.ramp_timer - 16'h0001;
      if (fud_pulse && new_ctrl[`DCW_RAMP_LOAD_FUD])
         st_nxt.ramp_timer = st_r.buf_ramp;

      // Frequency accumulator: hold clear beats auto clear beats tick
      // Core stop freezes both accumulators; the timer above still runs
      if (new_ctrl[`DCW_CLR_FREQ])
         st_nxt.freq_acc = 32'h0000_0000;
      else if (fud_pulse && new_ctrl[`DCW_AUTOCLR_FREQ])
         st_nxt.freq_acc = 32'h0000_0000;
      else if (tick && !new_ctrl[`DCW_PD_CORE])
         st_nxt.freq_acc = st_r.freq_acc + st_r.step;

      // Phase accumulator; sweep adds frequency accumulator to tuning word
      if (new_ctrl[`DCW_CLR_PHASE])
         st_nxt.phase_acc = 32'h0000_0000;
      else if (fud_pulse && new_ctrl[`DCW_AUTOCLR_PHASE])
         st_nxt.phase_acc = 32'h0000_0000;
      else if (!new_ctrl[`DCW_PD_CORE])
         st_nxt.phase_acc = st_r.phase_acc + TUNING_WORD_IN
                          + (new_ctrl[`DCW_SWEEP_EN] ? st_r.freq_acc : 32'h0000_0000);

      // Sync timing never stops; only the pin is gated
      // Half period of four core cycles gives the core clock over 8
      if (st_r.sync_cnt == `DCW_SYNC_HALF - 3'h1)
      begin
         st_nxt.sync_cnt = 3'h0;
         st_nxt.sync_clk = ~st_r.sync_clk;
      end
      else
         st_nxt.sync_cnt = st_r.sync_cnt + 3'h1;

      // Read data from the port buffers, registered onto the pins
      // Buffers, not live words, so software can check bytes before the strobe
      st_nxt.rd_data = byte_of(st_r.buf_ctrl, raddr, `DCW_CTRL_OFS, 3'h4)
                     | byte_of(st_r.buf_step, raddr, `DCW_STEP_OFS, 3'h4)
                     | byte_of({16'h0000, st_r.buf_ramp}, raddr, `DCW_RAMP_OFS, 3'h2);
   end

   // Edge terms on filtered levels
   assign wr_done   = ~st_r.wr_f & st_r.sync.wr[2] & (st_r.sync.wr[1] == st_r.sync.wr[2]);
   assign fud_pulse = ~st_r.fud_f & st_r.sync.frequency_update_strobe[2] & (st_r.sync.frequency_update_strobe[1] == st_r.sync.frequency_update_strobe[2]);

   // Address and data from stage 3, the same age as the strobe
   assign waddr     = st_r.sync.addr[17:12];
   assign wdata     = st_r.sync.data[23:16];
   assign raddr     = st_r.sync.addr[17:12];

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   // Synchronous reset; write and read strobes idle high, update strobe idles low
   // Buffers start equal to the live words so early reads show defaults
   always_ff @(posedge CLOCK_IN)
   begin
      if (!RESET_N_IN)
      begin
         st_r            <= '0;
         st_r.sync.wr    <= 3'h7;
         st_r.sync.rd    <= 3'h7;
         st_r.wr_f       <= 1'b1;
         st_r.rd_f       <= 1'b1;
         st_r.buf_ctrl   <= `DCW_CTRL_RESET;
         st_r.buf_step   <= `DCW_STEP_RESET;
         st_r.buf_ramp   <= `DCW_RAMP_RESET;
         st_r.ctrl       <= `DCW_CTRL_RESET;
         st_r.step       <= `DCW_STEP_RESET;
         st_r.ramp       <= `DCW_RAMP_RESET;
      end
      else
         st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Port drive while read strobe is low
   assign DATA_OUT      = st_r.rd_data;
   assign DATA_OE_N_OUT = st_r.rd_f;

   // Accumulators and sweep tick
   assign FREQ_ACC_OUT   = st_r.freq_acc;
   assign PHASE_ACC_OUT  = st_r.phase_acc;
   assign SWEEP_TICK_OUT = st_r.ctrl[`DCW_SWEEP_EN] & (st_r.ramp_timer == 16'h0000);

   // Charge pump scale decodes
   // Decodes follow the committed word, never the buffers
   always_comb
   begin
      case (st_r.ctrl[`DCW_FD_PUMP_HI:`DCW_FD_PUMP_LO])
         2'b01:   FD_PUMP_SCALE_OUT = 7'h14;
         2'b10:   FD_PUMP_SCALE_OUT = 7'h28;
         2'b11:   FD_PUMP_SCALE_OUT = 7'h3c;
         default: FD_PUMP_SCALE_OUT = 7'h00;
      endcase
   end

   // Final field: top bit clear gives no current, else low bits plus one
   assign FINAL_PUMP_SCALE_OUT = st_r.ctrl[`DCW_FINAL_PUMP_HI]
                               ? {1'b0, st_r.ctrl[`DCW_FINAL_PUMP_LO +: 2]} + 3'h1
                               : 3'h0;
   assign WIDE_PUMP_SCALE_OUT  = {st_r.ctrl[`DCW_WIDE_PUMP_HI:`DCW_WIDE_PUMP_LO], 1'b0};
   assign PUMP_OFFSET_OUT      = st_r.ctrl[`DCW_PUMP_OFFSET];
   assign PUMP_POL_INVERT_OUT  = st_r.ctrl[`DCW_PUMP_POL];
   // Bits 18 and 7 drive nothing
   assign FAST_LOCK_EN_OUT         = st_r.ctrl[`DCW_FAST_LOCK_EN];
   assign FAST_LOCK_USE_TUNING_OUT = ~st_r.ctrl[`DCW_FAST_LOCK_NOFTW];

   // Dividers and clock options
   assign REF_DIV_OUT      = div_ratio(st_r.ctrl[`DCW_REF_DIV_HI:`DCW_REF_DIV_LO]);
   assign FB_DIV_OUT       = div_ratio(st_r.ctrl[`DCW_FB_DIV_HI:`DCW_FB_DIV_LO]);
   assign REF_HALVE_EN_OUT = ~st_r.ctrl[`DCW_REF_HALVE_OFF];
   assign SYNC_CLOCK_OUT   = st_r.sync_clk & ~st_r.ctrl[`DCW_SYNC_OFF];

   // Modes, power and serial format
   assign SWEEP_MODE_OUT   = st_r.ctrl[`DCW_SWEEP_EN];
   assign SINE_SELECT_OUT  = st_r.ctrl[`DCW_SINE_SEL];
   assign MIXER_PD_OUT     = st_r.ctrl[`DCW_PD_MIXER];
   assign DETECTOR_PD_OUT  = st_r.ctrl[`DCW_PD_DETECTOR];
   assign CORE_STOP_OUT    = st_r.ctrl[`DCW_PD_CORE];
   assign FULL_SLEEP_OUT   = &st_r.ctrl[`DCW_PD_MIXER:`DCW_PD_CORE];
   assign SERIAL_BIDIR_OUT = ~st_r.ctrl[`DCW_SDIO_IN_ONLY];
   assign LSB_FIRST_OUT    = SERIAL_MODE_IN & st_r.ctrl[`DCW_LSB_FIRST];

endmodule : dcw_decode

// ===== verification/dcw_decode_properties.sv
/*
 Port assertions for the control word decoder.
 Assumes binding to dcw_decode on its single core clock.
*/
`timescale 1ns/1ps
module dcw_decode_properties
(
   // Clock, reset, mode
   input  wire logic        CLOCK_IN,
   input  wire logic        RESET_N_IN,
   input  wire logic        SERIAL_MODE_IN,
   input  wire logic [31:0] TUNING_WORD_IN,
   // Watched outputs
   input  wire logic [31:0] FREQ_ACC_OUT,
   input  wire logic [31:0] PHASE_ACC_OUT,
   input  wire logic        SWEEP_TICK_OUT,
   input  wire logic [6:0]  FD_PUMP_SCALE_OUT,
   input  wire logic [2:0]  FINAL_PUMP_SCALE_OUT,
   input  wire logic [3:0]  WIDE_PUMP_SCALE_OUT,
   input  wire logic [2:0]  REF_DIV_OUT,
   input  wire logic [2:0]  FB_DIV_OUT,
   input  wire logic        SWEEP_MODE_OUT,
   input  wire logic        MIXER_PD_OUT,
   input  wire logic        DETECTOR_PD_OUT,
   input  wire logic        CORE_STOP_OUT,
   input  wire logic        FULL_SLEEP_OUT,
   input  wire logic        LSB_FIRST_OUT
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN);
   ////////////////////////////////////////////////////////////
   // Decoded scales and dividers stay legal; sleep, bit order and tick follow their modes
   final_pump_a: assert property (FINAL_PUMP_SCALE_OUT <= 3'h4)
      else $error("final pump scale out of range");
   wide_pump_a: assert property (!WIDE_PUMP_SCALE_OUT[0] && WIDE_PUMP_SCALE_OUT <= 4'he)
      else $error("wide pump scale not even");
   detect_pump_a: assert property (FD_PUMP_SCALE_OUT inside {7'h00, 7'h14, 7'h28, 7'h3c})
      else $error("detect pump scale illegal");
   ref_div_a: assert property (REF_DIV_OUT inside {3'h1, 3'h2, 3'h4})
      else $error("reference divider illegal");
   fb_div_a: assert property (FB_DIV_OUT inside {3'h1, 3'h2, 3'h4})
      else $error("feedback divider illegal");
   full_sleep_a: assert property (FULL_SLEEP_OUT == (MIXER_PD_OUT && DETECTOR_PD_OUT && CORE_STOP_OUT))
      else $error("full sleep decode wrong");
   lsb_gate_a: assert property (LSB_FIRST_OUT |-> SERIAL_MODE_IN)
      else $error("lsb first outside serial mode");
   tick_mode_a: assert property (!SWEEP_MODE_OUT |-> !SWEEP_TICK_OUT)
      else $error("sweep tick in single tone");
   // Accumulator moves only on a tick, a clear or a mode commit
   freq_step_a: assert property ((FREQ_ACC_OUT != $past(FREQ_ACC_OUT)) |->
      ($past(SWEEP_TICK_OUT) || FREQ_ACC_OUT == 32'h0000_0000 || $changed(SWEEP_MODE_OUT)))
      else $error("frequency accumulator moved off tick");
   // Outputs show the word that steered the last phase update
   phase_add_a: assert property ((PHASE_ACC_OUT != 32'h0000_0000 && !CORE_STOP_OUT) |->
      (PHASE_ACC_OUT == $past(PHASE_ACC_OUT) + $past(TUNING_WORD_IN)
                        + (SWEEP_MODE_OUT ? $past(FREQ_ACC_OUT) : 32'h0000_0000)))
      else $error("phase accumulator step wrong");
   tick_c: cover property (SWEEP_TICK_OUT ##4 SWEEP_TICK_OUT);
   sleep_c: cover property (FULL_SLEEP_OUT);
   lsb_c: cover property (LSB_FIRST_OUT);
endmodule : dcw_decode_properties

bind dcw_decode dcw_decode_properties u_dcw_decode_properties (.CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN),
   .SERIAL_MODE_IN(SERIAL_MODE_IN), .FREQ_ACC_OUT(FREQ_ACC_OUT), .SWEEP_TICK_OUT(SWEEP_TICK_OUT),
   .FD_PUMP_SCALE_OUT(FD_PUMP_SCALE_OUT), .FINAL_PUMP_SCALE_OUT(FINAL_PUMP_SCALE_OUT),
   .WIDE_PUMP_SCALE_OUT(WIDE_PUMP_SCALE_OUT), .REF_DIV_OUT(REF_DIV_OUT), .FB_DIV_OUT(FB_DIV_OUT),
   .SWEEP_MODE_OUT(SWEEP_MODE_OUT), .MIXER_PD_OUT(MIXER_PD_OUT), .DETECTOR_PD_OUT(DETECTOR_PD_OUT),
   .CORE_STOP_OUT(CORE_STOP_OUT), .FULL_SLEEP_OUT(FULL_SLEEP_OUT), .LSB_FIRST_OUT(LSB_FIRST_OUT),
   .TUNING_WORD_IN(TUNING_WORD_IN), .PHASE_ACC_OUT(PHASE_ACC_OUT));

// ===== verification/dcw_host_model.sv
/*
 Host controller model on the parallel byte port.
 Assumes the bench calls its tasks; pins move at falling edges only.
*/
`timescale 1ns/1ps
module dcw_host_model
(
   // Clock
   input  wire logic       clock_in,
   // Port pins
   output logic            write_n_out,
   output logic            read_n_out,
   output logic [5:0]      addr_out,
   output logic [7:0]      data_out,
   output logic            update_out,
   // Read data and drive enable back
   input  wire logic [7:0] rdata_in,
   input  wire logic       oe_n_in
);
   localparam int HOLD = 5; // Margin over the 3 cycle pin filter
   ////////////////////////////////////////////////////////////
   // Idle pins at time zero
   initial
   begin
      write_n_out = 1'b1;
      read_n_out  = 1'b1;
      addr_out    = 6'h3f;
      data_out    = 8'h00;
      update_out  = 1'b0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock_in);
   endtask : wait_n
   // Released data shows the inverse so stale values never match
   task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
      addr_out    = a;
      data_out    = d;
      write_n_out = 1'b0;
      wait_n(HOLD);
      write_n_out = 1'b1;
      wait_n(HOLD);
      data_out    = ~d;
      wait_n(1);
   endtask : wr_byte
   task automatic rd_byte(input logic [5:0] a, output logic [7:0] d, output logic oe_n);
      addr_out   = a;
      read_n_out = 1'b0;
      wait_n(HOLD + 1);
      d          = rdata_in;
      oe_n       = oe_n_in;
      read_n_out = 1'b1;
      wait_n(HOLD + 1);
   endtask : rd_byte
   // Lowest address carries the low byte
   task automatic wr_word(input logic [5:0] base, input logic [31:0] w);
      for (int i = 0; i < 4; i++)
         wr_byte(base + 6'(i), w[8*i +: 8]);
   endtask : wr_word
   task automatic strobe();
      update_out = 1'b1;
      wait_n(HOLD);
      update_out = 1'b0;
      wait_n(HOLD);
   endtask : strobe
endmodule : dcw_host_model

// ===== verification/dcw_decode_tb.sv
/*
 Self-checking bench for the control word decoder.
 Assumes the host model drives the port and the bench the rest.
*/
`timescale 1ns/1ps
`include "dcw_map.svh"
module dcw_decode_tb;
   typedef struct packed {logic [31:0] ctrl; logic [2:0] fin; logic [3:0] wide;
      logic [6:0] fd; logic [2:0] rf; logic [2:0] fb;} dcw_row_s;
   // Control word beside its expected scales and dividers
   localparam dcw_row_s ROWS [8] = '{
      '{32'h0000_0018, 3'h0, 4'h0, 7'h00, 3'h1, 3'h1}, '{32'h4902_4d42, 3'h0, 4'h2, 7'h14, 3'h2, 3'h2},
      '{32'h9201_3211, 3'h0, 4'h4, 7'h28, 3'h4, 3'h4}, '{32'hdb00_9b1c, 3'h0, 4'h6, 7'h3c, 3'h4, 3'h4},
      '{32'h2400_0018, 3'h1, 4'h8, 7'h00, 3'h1, 3'h1}, '{32'h6d04_09a0, 3'h2, 4'ha, 7'h14, 3'h2, 3'h2},
      '{32'hb600_1200, 3'h3, 4'hc, 7'h28, 3'h4, 3'h4}, '{32'hff00_1b00, 3'h4, 4'he, 7'h3c, 3'h4, 3'h4}};
   logic        clk, rst_n, wr_n, rd_n, upd, serial, oe_n, tick, sync, rd_oe_n;
   logic        offs, pol, fl_en, fl_tun, halve, sweep, sine, mix, det, core, sleep, bidir, lsb;
   logic [5:0]  addr;
   logic [7:0]  wdata, rdata, b;
   logic [31:0] tuning, facc, pacc, c, a;
   logic [6:0]  fd;
   logic [3:0]  wide;
   logic [2:0]  fin, rdiv, fdiv;
   int          errors = 0, cmp_count = 0, hi;
   dcw_decode u_dcw_decode (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .WRITE_N_IN(wr_n), .READ_N_IN(rd_n),
      .ADDR_IN(addr), .DATA_IN(wdata), .DATA_OUT(rdata), .DATA_OE_N_OUT(oe_n), .FREQ_UPDATE_IN(upd),
      .SERIAL_MODE_IN(serial), .TUNING_WORD_IN(tuning), .FREQ_ACC_OUT(facc), .PHASE_ACC_OUT(pacc),
      .SWEEP_TICK_OUT(tick), .FD_PUMP_SCALE_OUT(fd), .FINAL_PUMP_SCALE_OUT(fin), .WIDE_PUMP_SCALE_OUT(wide),
      .PUMP_OFFSET_OUT(offs), .PUMP_POL_INVERT_OUT(pol), .FAST_LOCK_EN_OUT(fl_en),
      .FAST_LOCK_USE_TUNING_OUT(fl_tun), .REF_DIV_OUT(rdiv), .FB_DIV_OUT(fdiv), .REF_HALVE_EN_OUT(halve),
      .SYNC_CLOCK_OUT(sync), .SWEEP_MODE_OUT(sweep), .SINE_SELECT_OUT(sine), .MIXER_PD_OUT(mix),
      .DETECTOR_PD_OUT(det), .CORE_STOP_OUT(core), .FULL_SLEEP_OUT(sleep), .SERIAL_BIDIR_OUT(bidir),
      .LSB_FIRST_OUT(lsb));
   dcw_host_model u_dcw_host_model (.clock_in(clk), .write_n_out(wr_n), .read_n_out(rd_n),
      .addr_out(addr), .data_out(wdata), .update_out(upd), .rdata_in(rdata), .oe_n_in(oe_n));
   ////////////////////////////////////////////////////////////
   // Core clock, 25 ns period
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic finish_test();
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   // Commit a control word through the port
   task automatic set_ctrl(input logic [31:0] w);
      u_dcw_host_model.wr_word(`DCW_CTRL_OFS, w);
      u_dcw_host_model.strobe();
   endtask : set_ctrl
   // Watchdog, far beyond the under two thousand cycles needed
   initial
   begin
      repeat (30000) @(posedge clk);
      errors++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      rst_n  = 1'b0;
      serial = 1'b1;
      tuning = 32'h0000_1000;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      chk("reset_pd", 4'hc, {mix, det, core, sleep});
      chk("reset_oe", 1'b1, oe_n);
      for (int i = 0; i < 4; i++)
      begin
         u_dcw_host_model.rd_byte(6'(i), b, rd_oe_n);
         chk("read_oe", 1'b0, rd_oe_n);
         chk("ctrl_reset", 32'h0020_0018 >> (8 * i) & 32'h0000_00ff, b);
      end
      foreach (ROWS[i])
      begin
         c = ROWS[i].ctrl;
         set_ctrl(c);
         chk("final", ROWS[i].fin, fin);
         chk("wide", ROWS[i].wide, wide);
         chk("detect", ROWS[i].fd, fd);
         chk("ref_div", ROWS[i].rf, rdiv);
         chk("fb_div", ROWS[i].fb, fdiv);
         chk("pll", {c[17], ~c[16], c[13], c[10]}, {fl_en, fl_tun, offs, pol});
         chk("mode", {c[15], c[14]}, {sweep, sine});
         chk("clocks", {~c[6], ~c[1], c[0]}, {halve, bidir, lsb});
         chk("power", {c[4:2], &c[4:2]}, {mix, det, core, sleep});
      end
      // Sync pin held low, then a 1 in 8 square wave
      set_ctrl(32'h0000_0038);
      hi = 0;
      repeat (16) @(negedge clk) hi += int'(sync);
      chk("sync_off", 0, hi);
      set_ctrl(32'h0000_0018);
      hi = 0;
      repeat (16) @(negedge clk) hi += int'(sync);
      chk("sync_run", 8, hi);
      // Step byte order and an unmapped read
      u_dcw_host_model.wr_word(`DCW_STEP_OFS, 32'hffff_fffe);
      u_dcw_host_model.rd_byte(`DCW_STEP_OFS + 6'h3, b, rd_oe_n);
      chk("step_msb", 8'hff, b);
      u_dcw_host_model.rd_byte(6'h20, b, rd_oe_n);
      chk("unmapped", 8'h00, b);
      // Sweep with ramp divider 3 and a negative step
      u_dcw_host_model.wr_byte(`DCW_RAMP_OFS, 8'h03);
      u_dcw_host_model.wr_byte(`DCW_RAMP_OFS + 6'h1, 8'h00);
      set_ctrl(32'h0020_8018);
      hi = 0;
      while (tick !== 1'b1 && hi < 50)
      begin
         @(negedge clk);
         hi++;
      end
      a = facc;
      repeat (4) @(negedge clk);
      chk("tick_gap", 1'b1, tick);
      chk("step_add", a - 32'h0000_0002, facc);
      repeat (200) @(negedge clk);
      set_ctrl(32'h00a0_8018);
      chk("freq_auto", 1'b1, facc + 32'h0000_0040 <= 32'h0000_0040);
      set_ctrl(32'h0030_8018);
      chk("freq_hold", 32'h0000_0000, facc);
      // Phase clears: held, then one shot on update
      set_ctrl(32'h0028_0018);
      chk("phase_hold", 32'h0000_0000, pacc);
      set_ctrl(32'h0000_0018);
      repeat (400) @(negedge clk);
      set_ctrl(32'h0040_0018);
      chk("phase_auto", 1'b1, pacc < 32'h0001_0000);
      // Bit order flag gated by serial mode
      set_ctrl(32'h0000_0019);
      chk("lsb_serial", 1'b1, lsb);
      serial = 1'b0;
      @(negedge clk);
      chk("lsb_parallel", 1'b0, lsb);
      finish_test();
   end
endmodule : dcw_decode_tb
